// >>> design/gpsel_defs.svh
`ifndef GPSEL_DEFS_SVH
`define GPSEL_DEFS_SVH

// ****************************************************************
// Register word indices (byte address is four times the index)
// ****************************************************************
`define GPSEL_IDX_BUS_SEL   14'h1c00
`define GPSEL_IDX_PD_ONE    14'h1c17
`define GPSEL_IDX_PD_TWO    14'h1c18
`define GPSEL_IDX_PD_THREE  14'h1c19

// ****************************************************************
// Reset values and writable masks
// ****************************************************************
`define GPSEL_RST_BUS_SEL   12'h000
`define GPSEL_RST_PD_ONE    16'h0fff
`define GPSEL_RST_PD_TWO    16'h003f
`define GPSEL_RST_PD_THREE  16'h2600
`define GPSEL_MASK_PD_ONE   16'h0fff
`define GPSEL_MASK_PD_TWO   16'h003f
`define GPSEL_MASK_PD_THREE 16'h3fff
// Pulldown enables per pad after reset, bit 0 is line 4
`define GPSEL_RST_PD_EN     28'h601ff00

// ****************************************************************
// Function slots on each pad
// ****************************************************************
`define GPSEL_SLOT_GPIO     2'h0
`define GPSEL_SLOT_PRIMARY  2'h1
`define GPSEL_SLOT_HOST     2'h2
`define GPSEL_SLOT_ALT      2'h3
`define GPSEL_NUM_SLOTS     4

// ****************************************************************
// Mode field encodings
// ****************************************************************
`define GPSEL_SP_CARD       2'h0
`define GPSEL_SP_SERIAL     2'h1
`define GPSEL_PP_NAMED      2'h0
`define GPSEL_PP_HOST       2'h1
`define GPSEL_PP_GPIO       2'h2
`define GPSEL_PP_ALT        2'h3

// ****************************************************************
// Line groups
// ****************************************************************
`define GPSEL_NUM_PINS      28
`define GPSEL_FIRST_LINE    4
`define GPSEL_SP0_LAST      5
`define GPSEL_SP1_LAST      11
`define GPSEL_HPD_FIRST     12
`define GPSEL_HPD_LAST      17
`define GPSEL_SND2_LAST     20
`define GPSEL_EMA_FIRST     21
`define GPSEL_EMA_LAST      26
`define GPSEL_PD3_HI_OFS    18
`define GPSEL_BUS_SEL_W     12

`endif

// >>> design/gpsel_pkg.sv
`include "gpsel_defs.svh"

package gpsel_pkg;

  // Drive of one function onto all pads
  typedef struct packed {
    logic [`GPSEL_NUM_PINS-1:0] out;  // Output level per pad
    logic [`GPSEL_NUM_PINS-1:0] oe;   // Output enable per pad
  } gpsel_pin_t;

  // External bus select register layout
  typedef struct packed {
    logic [5:0] addr_sel;  // Lines 21..26: 1 takes address bits
    logic [1:0] pp;        // Parallel port mode
    logic [1:0] sp1;       // Serial port one mode
    logic [1:0] sp0;       // Serial port zero mode
  } gpsel_bus_sel_t;

endpackage

// >>> design/gpsel_sync.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Two-flop synchroniser for pad levels
// ****************************************************************
module gpsel_sync #(
  parameter int WIDTH = 28  // Number of levels to carry
) (
  input  wire logic             sys_clk,  // System clock
  input  wire logic             rst,      // Synchronous reset
  input  wire logic [WIDTH-1:0] d,        // Asynchronous levels
  output logic      [WIDTH-1:0] q         // Synchronised levels
);

  logic [WIDTH-1:0] meta;  // First stage, read only by q

  // Both stages clear on reset; nothing else looks at meta
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

// >>> design/gpsel_mux.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpsel_defs.svh"

// ****************************************************************
// Registered per-pad function multiplexer
// ****************************************************************
module gpsel_mux
  import gpsel_pkg::*;
(
  input  wire logic                                 sys_clk,
  input  wire logic                                 rst,
  input  wire logic [`GPSEL_NUM_PINS-1:0][1:0]      pin_sel,
  input  wire gpsel_pin_t [`GPSEL_NUM_SLOTS-1:0]    func_drive,
  input  wire logic [`GPSEL_NUM_PINS-1:0]           pad_in_sync,
  output logic      [`GPSEL_NUM_PINS-1:0]           pad_out,
  output logic      [`GPSEL_NUM_PINS-1:0]           pad_oe,
  output logic [`GPSEL_NUM_SLOTS-1:0][`GPSEL_NUM_PINS-1:0] func_in
);

  logic [`GPSEL_NUM_PINS-1:0] next_pad_out;  // Selected level
  logic [`GPSEL_NUM_PINS-1:0] next_pad_oe;   // Selected enable
  logic [`GPSEL_NUM_SLOTS-1:0][`GPSEL_NUM_PINS-1:0] next_func_in;

  // Per pad: pick the owner, and feed the pad level only to it
  for (genvar i = 0; i < `GPSEL_NUM_PINS; i++) begin : g_pad
    assign next_pad_out[i] = func_drive[pin_sel[i]].out[i];
    assign next_pad_oe[i]  = func_drive[pin_sel[i]].oe[i];
    for (genvar s = 0; s < `GPSEL_NUM_SLOTS; s++) begin : g_slot
      // A function that does not own the pad sees a quiet low
      assign next_func_in[s][i] = pad_in_sync[i] &
                                  (pin_sel[i] == 2'(s));
    end
  end

  // Registering every pad path keeps mode changes glitch free
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pad_out <= '0;
      pad_oe  <= '0;
      func_in <= '0;
    end else begin
      pad_out <= next_pad_out;
      pad_oe  <= next_pad_oe;
      func_in <= next_func_in;
    end
  end

endmodule

`default_nettype wire

// >>> design/gpsel_top.sv
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "gpsel_defs.svh"

// ****************************************************************
// Summary of operation
// - Lines 4-5: card zero, serial, GPIO
// - Lines 6-11: card one, multichannel, GPIO
// - Lines 12-17: GPIO or host data 2-7
// - Lines 18-20,27: sound two, host, GPIO, SPI
// - Lines 28-31: UART, host, GPIO, sound three
// - Lines 21-26: per-pin address bit select
// - First inhibit register: lines 4-11 pulldowns
// - Second inhibit register: lines 21-26 pulldowns
// - Third inhibit register: lines 12-20, 27-31
// - Reset: pulldown off 4-11, 21-28, 31
// - Reset: pulldown on 12-20, 29, 30
// - Reset: each pad takes its first function
// ****************************************************************

module gpsel_top
  import gpsel_pkg::*;
(
  input  wire logic                              sys_clk,
  input  wire logic                              rst,
  // APB slave
  input  wire logic [15:0]                       paddr,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // Function drives, one slot each
  input  wire gpsel_pin_t [`GPSEL_NUM_SLOTS-1:0] func_drive,
  output logic [`GPSEL_NUM_SLOTS-1:0][`GPSEL_NUM_PINS-1:0] func_in,
  // Pads, bit 0 is line 4
  input  wire logic [`GPSEL_NUM_PINS-1:0]        pad_in,
  output logic      [`GPSEL_NUM_PINS-1:0]        pad_out,
  output logic      [`GPSEL_NUM_PINS-1:0]        pad_oe,
  output logic      [`GPSEL_NUM_PINS-1:0]        pulldown_en
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  gpsel_bus_sel_t external_bus_select_reg;      // Mode fields
  logic [15:0]    pulldown_inhibit_port_one;    // Lines 4..11
  logic [15:0]    pulldown_inhibit_port_two;    // Lines 21..26
  logic [15:0]    pulldown_inhibit_port_three;  // 12..20, 27..31
  gpsel_bus_sel_t next_bus_sel;                 // Next mode fields
  logic [15:0]    next_pd_one;                  // Next inhibit one
  logic [15:0]    next_pd_two;                  // Next inhibit two
  logic [15:0]    next_pd_three;                // Next inhibit three
  logic [31:0]    next_prdata;                  // Read data
  logic           next_pready;                  // Access answer
  logic           next_pslverr;                 // Unmapped access
  logic [13:0]    word_idx;                     // Word index
  logic           hit_bus_sel;                  // Decode hits
  logic           hit_pd_one;
  logic           hit_pd_two;
  logic           hit_pd_three;
  logic           mapped;                       // Any register hit
  logic           wr_ack;                       // Write taking effect
  logic [`GPSEL_NUM_PINS-1:0]      pad_in_sync;      // Synced pads
  logic [`GPSEL_NUM_PINS-1:0][1:0] pin_sel;          // Owner slot
  logic [`GPSEL_NUM_PINS-1:0]      next_pulldown_en; // Pulldowns

  // ****************************************************************
  // APB address decode
  // ****************************************************************
  // Byte lanes below a word are ignored; a misaligned address
  // still selects the word it falls in
  assign word_idx     = paddr[15:2];
  assign hit_bus_sel  = (word_idx == `GPSEL_IDX_BUS_SEL);
  assign hit_pd_one   = (word_idx == `GPSEL_IDX_PD_ONE);
  assign hit_pd_two   = (word_idx == `GPSEL_IDX_PD_TWO);
  assign hit_pd_three = (word_idx == `GPSEL_IDX_PD_THREE);
  assign mapped       = hit_bus_sel | hit_pd_one | hit_pd_two |
                        hit_pd_three;
  // A write lands only at the edge where pready is seen high
  assign wr_ack       = psel & penable & pready & pwrite & mapped;

  // ****************************************************************
  // Register file
  // ****************************************************************
  // Next register values; unmapped writes change nothing
  always_comb begin
    next_bus_sel  = external_bus_select_reg;
    next_pd_one   = pulldown_inhibit_port_one;
    next_pd_two   = pulldown_inhibit_port_two;
    next_pd_three = pulldown_inhibit_port_three;
    if (wr_ack) begin
      if (hit_bus_sel) begin
        // Mode fields for all shared pads
        next_bus_sel = gpsel_bus_sel_t'(
          pwdata[`GPSEL_BUS_SEL_W-1:0]);
      end
      if (hit_pd_one) begin
        // Bits above line 11 are reserved and stay zero
        next_pd_one = pwdata[15:0] & `GPSEL_MASK_PD_ONE;
      end
      if (hit_pd_two) begin
        next_pd_two = pwdata[15:0] & `GPSEL_MASK_PD_TWO;
      end
      if (hit_pd_three) begin
        next_pd_three = pwdata[15:0] & `GPSEL_MASK_PD_THREE;
      end
    end
  end

  // Register storage with documented reset states
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      external_bus_select_reg     <= `GPSEL_RST_BUS_SEL;
      pulldown_inhibit_port_one   <= `GPSEL_RST_PD_ONE;
      pulldown_inhibit_port_two   <= `GPSEL_RST_PD_TWO;
      pulldown_inhibit_port_three <= `GPSEL_RST_PD_THREE;
    end else begin
      external_bus_select_reg     <= next_bus_sel;
      pulldown_inhibit_port_one   <= next_pd_one;
      pulldown_inhibit_port_two   <= next_pd_two;
      pulldown_inhibit_port_three <= next_pd_three;
    end
  end

  // ****************************************************************
  // APB answer
  // ****************************************************************
  // One wait-free access cycle: the answer is prepared during setup
  always_comb begin
    next_pready  = psel & ~penable;
    next_pslverr = psel & ~penable & ~mapped;
    next_prdata  = 32'h0000_0000;
    if (psel & ~penable & ~pwrite) begin
      // Unused upper bits read as zero
      if (hit_bus_sel) begin
        next_prdata = 32'(external_bus_select_reg);
      end else if (hit_pd_one) begin
        next_prdata = 32'(pulldown_inhibit_port_one);
      end else if (hit_pd_two) begin
        next_prdata = 32'(pulldown_inhibit_port_two);
      end else if (hit_pd_three) begin
        next_prdata = 32'(pulldown_inhibit_port_three);
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  // Answer flops; pready is a single-cycle pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // ****************************************************************
  // Pad ownership decode
  // ****************************************************************
  // Slot owning a given line under the current mode fields
  function automatic logic [1:0] slot_for(input int line,
                                          input gpsel_bus_sel_t m);
    logic [1:0] s;
    s = `GPSEL_SLOT_GPIO;
    if (line <= `GPSEL_SP0_LAST) begin
      // Card port zero, buffered serial port or GPIO
      case (m.sp0)
        `GPSEL_SP_CARD:   s = `GPSEL_SLOT_PRIMARY;
        `GPSEL_SP_SERIAL: s = `GPSEL_SLOT_ALT;
        default:          s = `GPSEL_SLOT_GPIO;
      endcase
    end else if (line <= `GPSEL_SP1_LAST) begin
      // Card port one, multichannel serial or GPIO
      case (m.sp1)
        `GPSEL_SP_CARD:   s = `GPSEL_SLOT_PRIMARY;
        `GPSEL_SP_SERIAL: s = `GPSEL_SLOT_ALT;
        default:          s = `GPSEL_SLOT_GPIO;
      endcase
    end else if (line <= `GPSEL_HPD_LAST) begin
      // Host data bits 2..7 or GPIO only
      s = (m.pp == `GPSEL_PP_HOST) ? `GPSEL_SLOT_HOST
                                   : `GPSEL_SLOT_GPIO;
    end else if (line >= `GPSEL_EMA_FIRST &&
                 line <= `GPSEL_EMA_LAST) begin
      // Each address line has a private select bit
      s = m.addr_sel[line - `GPSEL_EMA_FIRST]
          ? `GPSEL_SLOT_PRIMARY : `GPSEL_SLOT_GPIO;
    end else begin
      // Sound two / UART first, host, GPIO, SPI / sound three
      case (m.pp)
        `GPSEL_PP_NAMED: s = `GPSEL_SLOT_PRIMARY;
        `GPSEL_PP_HOST:  s = `GPSEL_SLOT_HOST;
        `GPSEL_PP_ALT:   s = `GPSEL_SLOT_ALT;
        default:         s = `GPSEL_SLOT_GPIO;
      endcase
    end
    return s;
  endfunction

  // ****************************************************************
  // Per-line selection and pulldown mapping
  // ****************************************************************
  for (genvar i = 0; i < `GPSEL_NUM_PINS; i++) begin : g_line
    localparam int LINE = i + `GPSEL_FIRST_LINE;
    assign pin_sel[i] = slot_for(LINE, external_bus_select_reg);
    // A set inhibit bit switches the pulldown off
    if (LINE <= `GPSEL_SP1_LAST) begin : g_one
      assign next_pulldown_en[i] =
        ~pulldown_inhibit_port_one[LINE];
    end else if (LINE <= `GPSEL_SND2_LAST) begin : g_three_lo
      assign next_pulldown_en[i] =
        ~pulldown_inhibit_port_three[LINE - `GPSEL_HPD_FIRST];
    end else if (LINE <= `GPSEL_EMA_LAST) begin : g_two
      assign next_pulldown_en[i] =
        ~pulldown_inhibit_port_two[LINE - `GPSEL_EMA_FIRST];
    end else begin : g_three_hi
      assign next_pulldown_en[i] =
        ~pulldown_inhibit_port_three[LINE - `GPSEL_PD3_HI_OFS];
    end
  end

  // Pulldown controls go out through a flop each
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulldown_en <= `GPSEL_RST_PD_EN;
    end else begin
      pulldown_en <= next_pulldown_en;
    end
  end

  // ****************************************************************
  // Pad input synchroniser and function multiplexer
  // ****************************************************************
  gpsel_sync #(
    .WIDTH (`GPSEL_NUM_PINS)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (pad_in),
    .q       (pad_in_sync)
  );

  gpsel_mux u_mux (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .pin_sel     (pin_sel),
    .func_drive  (func_drive),
    .pad_in_sync (pad_in_sync),
    .pad_out     (pad_out),
    .pad_oe      (pad_oe),
    .func_in     (func_in)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // The routing checks skip the release edge: the pad flops still
  // load their reset value there, whatever the mode fields say
  sp0_card_a: assert property (
    !rst && external_bus_select_reg.sp0 == `GPSEL_SP_CARD |=>
      pad_out[0] == $past(func_drive[`GPSEL_SLOT_PRIMARY].out[0]))
    else $error("line 4 not routed to card port zero");

  sp1_serial_a: assert property (
    !rst && external_bus_select_reg.sp1 == `GPSEL_SP_SERIAL |=>
      pad_oe[2] == $past(func_drive[`GPSEL_SLOT_ALT].oe[2]))
    else $error("line 6 not routed to multichannel serial");

  host_data_a: assert property (
    !rst && external_bus_select_reg.pp == `GPSEL_PP_HOST |=>
      pad_out[8] == $past(func_drive[`GPSEL_SLOT_HOST].out[8]))
    else $error("line 12 not routed to host data");

  spi_route_a: assert property (
    !rst && external_bus_select_reg.pp == `GPSEL_PP_ALT |=>
      pad_out[23] == $past(func_drive[`GPSEL_SLOT_ALT].out[23]))
    else $error("line 27 not routed to SPI");

  uart_route_a: assert property (
    !rst && external_bus_select_reg.pp == `GPSEL_PP_NAMED |=>
      pad_out[27] == $past(func_drive[`GPSEL_SLOT_PRIMARY].out[27]))
    else $error("line 31 not routed to UART");

  addr_sel_a: assert property (
    !rst && external_bus_select_reg.addr_sel[0] |=>
      pad_out[17] == $past(func_drive[`GPSEL_SLOT_PRIMARY].out[17]))
    else $error("line 21 not routed to address bit");

  pd_one_wr_a: assert property (
    wr_ack && hit_pd_one |-> ##2
      pulldown_en[7:0] == ~$past(pwdata[11:4], 2))
    else $error("first inhibit write not applied");

  pd_two_wr_a: assert property (
    wr_ack && hit_pd_two |-> ##2
      pulldown_en[22:17] == ~$past(pwdata[5:0], 2))
    else $error("second inhibit write not applied");

  pd_three_wr_a: assert property (
    wr_ack && hit_pd_three |-> ##2
      pulldown_en[16:8] == ~$past(pwdata[8:0], 2) &&
      pulldown_en[27:23] == ~$past(pwdata[13:9], 2))
    else $error("third inhibit write not applied");

  pd_off_rst_a: assert property (disable iff (1'b0)
    rst |=> pulldown_en[7:0] == 8'h00 &&
            pulldown_en[24:17] == 8'h00 && !pulldown_en[27])
    else $error("pulldown on after reset");

  pd_on_rst_a: assert property (disable iff (1'b0)
    rst |=> &pulldown_en[16:8] && &pulldown_en[26:25])
    else $error("pulldown off after reset");

  first_name_a: assert property (
    $fell(rst) |=>
      pad_out[8] == $past(func_drive[`GPSEL_SLOT_GPIO].out[8]) &&
      pad_out[14] == $past(func_drive[`GPSEL_SLOT_PRIMARY].out[14]))
    else $error("pad not on first function after reset");

  mode_next_a: assert property (
    wr_ack && hit_bus_sel |=>
      external_bus_select_reg == $past(pwdata[11:0]) ##1
      pad_out[0] == $past(func_drive[pin_sel[0]].out[0]))
    else $error("mode write not applied at next edge");

  apb_ready_a: assert property (
    !rst && psel && !penable |=> pready ##1 !pready)
    else $error("pready not a one-cycle answer");

endmodule

`default_nettype wire

// >>> test/gpsel_far.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpsel_defs.svh"

// ****************************************************************
// Peripheral controllers and board pins on the far side
// ****************************************************************
module gpsel_far
  import gpsel_pkg::*;
(
  input  wire logic [27:0]                  ptn,          // Drive pattern
  input  wire logic [27:0]                  board,        // Board level
  input  wire logic [27:0]                  pad_out,      // Pad drive
  input  wire logic [27:0]                  pad_oe,       // Pad enable
  input  wire logic [27:0]                  pulldown_en,  // Pulldowns on
  output gpsel_pin_t [`GPSEL_NUM_SLOTS-1:0] func_drive,   // Slot drives
  output logic      [27:0]                  pad_in        // Pad level
);
  // Each slot gets its own out/oe pair, so a wrong owner always shows
  always_comb begin
    for (int s = 0; s < `GPSEL_NUM_SLOTS; s++) begin
      func_drive[s].out = (s % 2 == 1) ? ~ptn : ptn;
      func_drive[s].oe  = (s >= 2) ? '1 : '0;
    end
  end
  // Driven pad reads its drive; an idle pulled-down pad reads low
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ~pulldown_en & board);
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpsel_defs.svh"

// ****************************************************************
// Testbench top
// ****************************************************************
module tb_top
  import gpsel_pkg::*;
;
  logic                                     sys_clk, rst;
  logic [15:0]                              paddr;        // APB address
  logic                                     psel, penable, pwrite, pready;
  logic                                     pslverr;
  logic [31:0]                              pwdata, prdata;
  gpsel_pin_t [`GPSEL_NUM_SLOTS-1:0]        func_drive;
  logic [`GPSEL_NUM_SLOTS-1:0][27:0]        func_in;
  logic [27:0]                              pad_in, pad_out, pad_oe;
  logic [27:0]                              pulldown_en, ptn, board;
  int                                       mismatches, checked;
  logic [31:0]                              rd;           // Read data
  logic                                     er;           // Slave error

  gpsel_top uut (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .func_drive(func_drive),
    .func_in(func_in), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pulldown_en(pulldown_en));
  gpsel_far far (.ptn(ptn), .board(board), .pad_out(pad_out),
    .pad_oe(pad_oe), .pulldown_en(pulldown_en), .func_drive(func_drive),
    .pad_in(pad_in));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  // One APB transfer; waits for pready as long as it takes, the
  // watchdog alone ends a hang
  task automatic apb(input logic [15:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    // No wait states: the answer stands in the first access cycle
    chk(n == 1, "pready late");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Owning slot: 0 GPIO, 1 primary, 2 host data, 3 alternate
  function automatic logic [1:0] sp_slot(logic [1:0] m);
    return (m == 2'h0) ? 2'h1 : (m == 2'h1) ? 2'h3 : 2'h0;
  endfunction
  function automatic logic [1:0] slot_of(int l, gpsel_bus_sel_t b);
    if (l <= 5) return sp_slot(b.sp0);
    if (l <= 11) return sp_slot(b.sp1);
    if (l >= 21 && l <= 26) return b.addr_sel[l-21] ? 2'h1 : 2'h0;
    if (b.pp == 2'h1) return 2'h2;
    if (l <= 17 || b.pp == 2'h2) return 2'h0;
    return (b.pp == 2'h0) ? 2'h1 : 2'h3;
  endfunction

  // Pulldown on where its inhibit bit is clear
  function automatic logic [27:0] pd_exp(logic [15:0] a, b, c);
    logic [27:0] r;
    int l;
    for (int i = 0; i < 28; i++) begin
      l = i + 4;
      r[i] = ~(l <= 11 ? a[l] : l <= 20 ? c[l-12] :
               l <= 26 ? b[l-21] : c[l-18]);
    end
    return r;
  endfunction

  // Pads follow the owner; func_in only once sync has settled
  task automatic check_pads(input gpsel_bus_sel_t b, input bit full);
    logic [27:0] eo, ee;
    logic [3:0][27:0] ef;
    logic [1:0] s;
    ef = '0;
    for (int i = 0; i < 28; i++) begin
      s = slot_of(i + 4, b);
      eo[i] = s[0] ^ ptn[i];
      ee[i] = s[1];
      ef[s][i] = pad_in[i];
    end
    chk(pad_out === eo && pad_oe === ee, "pad routing");
    if (full) chk(func_in === ef, "func_in routing");
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    chk(pulldown_en === 28'h601ff00, "reset pulldowns");
    check_pads(12'h000, 1'b1);
    apb({`GPSEL_IDX_PD_THREE, 2'b00}, 1'b0, 32'h0);
    chk(rd === 32'h2600 && er === 1'b0, "inhibit three reset");
    $display("test reset done");
  endtask

  // Reserved bits must read back zero after an all-ones write
  task automatic t_pulldown;
    logic [15:0] v [3];
    logic [27:0] e;
    v = '{16'hf0a5, 16'hffea, 16'hffff};
    e = pd_exp(16'h00a5, 16'h002a, 16'h3fff);
    for (int k = 0; k < 3; k++)
      apb({`GPSEL_IDX_PD_ONE + 14'(k), 2'b00}, 1'b1, {16'h0, v[k]});
    apb({`GPSEL_IDX_PD_THREE, 2'b00}, 1'b0, 32'h0);
    chk(rd === 32'h3fff, "inhibit three mask");
    repeat (2) @(posedge sys_clk);
    chk(pulldown_en === e, "pulldowns");
    $display("test pulldown done");
  endtask

  // Every mode of each field, each address select set and clear
  task automatic t_modes;
    gpsel_bus_sel_t b;
    for (int m = 0; m < 4; m++) begin
      b = {6'(6'h15 << m), 2'(m), 2'(3 - m), 2'(m)};
      ptn <= ~ptn;
      board <= board ^ 28'h0ff00f0;
      apb({`GPSEL_IDX_BUS_SEL, 2'b00}, 1'b1, {20'h0, b});
      repeat (2) @(posedge sys_clk);
      check_pads(b, 1'b0);
      repeat (3) @(posedge sys_clk);
      check_pads(b, 1'b1);
    end
    $display("test modes done");
  endtask

  task automatic t_unmapped;
    apb(16'h7004, 1'b1, 32'hffff);
    chk(er === 1'b1, "unmapped write");
    apb(16'h7004, 1'b0, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped read");
    $display("test unmapped done");
  endtask

  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************************************
  // Clock, main sequence and watchdog
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    rst        = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 16'h0;
    pwdata     = 32'h0;
    ptn        = 28'h5a5a5a5;
    board      = 28'hc3c3c3c;
    mismatches = 0;
    checked    = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    t_reset();
    t_pulldown();
    t_modes();
    t_unmapped();
    print_verdict();
  end
  // Tests need well under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
